// ===== core/cmr_top.sv
// Operation
// - status at 0x04, rate at 0x05
// - bit 7 set while computing heading
// - bit 6 set while computing calibration
// - bit 5 enables heading smoothing filter
// - bit 4 continuous, bit 3 standby
// - bits 2..0 orientation, level by default
// - 0x70 enters, 0x7F leaves calibration
// - gather readings, update offsets on exit
// - 5 ms power-up wait, then continuous mode
// - six bytes via 0x33, msb first pairs
// - tenths of degree, heading 0..3600, tilt 1800
// - read returns bytes of last command
// - 0x75 to continuous, 0x76 to standby
`timescale 1ns/1ns
`include "cmr_params.svh"
module cmr_top
  import cmr_pkg::*;
#(
  parameter int PWRUP_CYC = `CMR_PWRUP_MS * `CMR_CLK_KHZ,
  parameter int PER_1HZ = `CMR_PER_1HZ_MS * `CMR_CLK_KHZ,
  parameter int PER_5HZ = `CMR_PER_5HZ_MS * `CMR_CLK_KHZ,
  parameter int PER_10HZ = `CMR_PER_10HZ_MS * `CMR_CLK_KHZ
) (
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic [15:0] HEADING_RAW,
  input wire logic [15:0] PITCH_RAW,
  input wire logic [15:0] ROLL_RAW,
  input wire logic [15:0] MAG_X,
  input wire logic [15:0] MAG_Y,
  input wire logic [15:0] MAG_Z,
  input wire logic MAG_VALID,
  output logic [15:0] CAL_OFFSET_X,
  output logic [15:0] CAL_OFFSET_Y,
  output logic [15:0] CAL_OFFSET_Z,
  output logic [15:0] CAL_SPAN_X,
  output logic [15:0] CAL_SPAN_Y,
  output logic [15:0] CAL_SPAN_Z
);
  localparam int PW = $clog2(PWRUP_CYC + 1);
  localparam logic signed [15:0] TILT_MAX = `CMR_TILT_MAX;
  localparam logic signed [15:0] TILT_MIN = -TILT_MAX;
  if (PWRUP_CYC < 1) begin : g_bad
    $error("power-up hold-off needs at least one cycle");
  end

  // power-up hold-off: bus is ignored until it expires
  logic [PW-1:0] pwr_cnt_reg; // cycles since reset release
  logic ready_reg; // core accepts its address
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      pwr_cnt_reg <= '0;
      ready_reg <= 1'b0;
    end else if (!ready_reg) begin
      pwr_cnt_reg <= pwr_cnt_reg + 1'b1;
      ready_reg <= (pwr_cnt_reg == PW'(PWRUP_CYC - 1));
    end
  end

  // serial slave
  logic wr_start, wr_valid, rd_start, rd_take;
  logic [7:0] wr_data; // byte just received
  logic [7:0] rd_byte; // byte offered to the reader
  cmr_i2c_slave u_bus (
    .clk(CLOCK),
    .rst_n(RESETN),
    .scl_in(SCL_IN),
    .sda_in(SDA_IN),
    .sda_out(SDA_OUT),
    .sda_oe(SDA_OE),
    .accept(ready_reg),
    .rd_data(rd_byte),
    .wr_start(wr_start),
    .wr_valid(wr_valid),
    .wr_data(wr_data),
    .rd_start(rd_start),
    .rd_take(rd_take)
  );

  // command parser
  cmr_parse_st_t pst_reg, pst_next;
  logic [7:0] cmd_reg; // last command byte
  logic [7:0] ee_addr_reg; // argument of byte read or write
  wire cmd_v = wr_valid && (pst_reg == P_CMD);
  wire arg1_v = wr_valid && (pst_reg == P_EE_ADDR);
  wire arg2_v = wr_valid && (pst_reg == P_EE_DATA);
  wire head_cmd = cmd_v && (wr_data == `CMR_CMD_HEAD);
  wire cal_on_cmd = cmd_v && (wr_data == `CMR_CMD_CAL_ON);
  wire cal_off_cmd = cmd_v && (wr_data == `CMR_CMD_CAL_OFF);
  wire run_cmd = cmd_v && (wr_data == `CMR_CMD_RUN);
  wire stdby_cmd = cmd_v && (wr_data == `CMR_CMD_STDBY);
  wire lvl_cmd = cmd_v && (wr_data == `CMR_CMD_LEVEL);
  wire edge_cmd = cmd_v && (wr_data == `CMR_CMD_EDGE);
  wire front_cmd = cmd_v && (wr_data == `CMR_CMD_FRONT);
  wire ee_cmd = (wr_data == `CMR_CMD_EE_RD) || (wr_data == `CMR_CMD_EE_WR);
  wire ee_rd_load = arg1_v && (cmd_reg == `CMR_CMD_EE_RD);
  wire ee_wr_rate = arg2_v && (ee_addr_reg == `CMR_OFS_RATE);
  wire ee_wr_stat = arg2_v && (ee_addr_reg == `CMR_OFS_STATUS);

  // next parser state; a new address write restarts it
  always_comb begin
    pst_next = pst_reg;
    if (wr_start) begin
      pst_next = P_CMD;
    end else if (wr_valid) begin
      case (pst_reg)
        P_CMD: pst_next = ee_cmd ? P_EE_ADDR : P_IGNORE;
        P_EE_ADDR: pst_next = (cmd_reg == `CMR_CMD_EE_WR) ? P_EE_DATA : P_IGNORE;
        default: pst_next = P_IGNORE; // surplus bytes dropped
      endcase
    end
  end

  // parser registers
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      pst_reg <= P_IGNORE;
      cmd_reg <= 8'h00;
      ee_addr_reg <= 8'h00;
    end else begin
      pst_reg <= pst_next;
      if (cmd_v) cmd_reg <= wr_data;
      if (arg1_v) ee_addr_reg <= wr_data;
    end
  end

  // mode state behind the status and rate bytes
  logic run_reg, stdby_reg, filter_reg, cal_mode_reg;
  logic [2:0] orient_reg; // front, edge, level
  logic [7:0] rate_reg; // rate byte as written
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      run_reg <= 1'b1;
      stdby_reg <= 1'b0;
      filter_reg <= 1'b0;
      cal_mode_reg <= 1'b0;
      orient_reg <= `CMR_RST_ORIENT;
      rate_reg <= `CMR_RST_RATE;
    end else begin
      if (run_cmd) begin
        run_reg <= 1'b1;
        stdby_reg <= 1'b0;
      end else if (stdby_cmd) begin
        run_reg <= 1'b0;
        stdby_reg <= 1'b1;
      end
      if (lvl_cmd) orient_reg <= 3'h1;
      else if (edge_cmd) orient_reg <= 3'h2;
      else if (front_cmd) orient_reg <= 3'h4;
      if (cal_on_cmd) cal_mode_reg <= 1'b1;
      else if (cal_off_cmd) cal_mode_reg <= 1'b0;
      // only the filter bit of the status byte is host-writable
      if (ee_wr_stat) filter_reg <= wr_data[`CMR_BIT_FILT];
      if (ee_wr_rate) rate_reg <= wr_data;
    end
  end

  // measurement pacing from the rate code
  logic meas_tick; // one pulse per update period
  cmr_rate_timer #(.P1(PER_1HZ), .P5(PER_5HZ), .P10(PER_10HZ)) u_rate (
    .clk(CLOCK),
    .rst_n(RESETN),
    .run(run_reg),
    .rate_sel(rate_reg[1:0]),
    .tick(meas_tick)
  );

  // heading computation window and snapshot
  logic [7:0] comp_cnt_reg; // cycles of computation left
  logic [15:0] head_snap_reg, pitch_snap_reg, roll_snap_reg;
  wire comp_busy = (comp_cnt_reg != 8'h00);
  wire comp_done = (comp_cnt_reg == 8'h01);
  wire [15:0] head_clamp = (HEADING_RAW > `CMR_HEAD_MAX) ? `CMR_HEAD_MAX : HEADING_RAW;
  // three parts old, one part new; wrap through north is not unwound
  wire [17:0] iir_sum = 18'(head_snap_reg) * 18'h3 + 18'(head_clamp);

  // tilt limited to the documented span
  function automatic logic [15:0] clamp_tilt(input logic [15:0] v);
    if ($signed(v) > TILT_MAX) clamp_tilt = TILT_MAX;
    else if ($signed(v) < TILT_MIN) clamp_tilt = TILT_MIN;
    else clamp_tilt = v;
  endfunction : clamp_tilt

  // new angles are published only at the end of the window
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      comp_cnt_reg <= 8'h00;
      head_snap_reg <= 16'h0000;
      pitch_snap_reg <= 16'h0000;
      roll_snap_reg <= 16'h0000;
    end else begin
      if (meas_tick) comp_cnt_reg <= `CMR_COMP_CYC;
      else if (comp_busy) comp_cnt_reg <= comp_cnt_reg - 8'h01;
      if (comp_done) begin
        head_snap_reg <= filter_reg ? iir_sum[17:2] : head_clamp;
        pitch_snap_reg <= clamp_tilt(PITCH_RAW);
        roll_snap_reg <= clamp_tilt(ROLL_RAW);
      end
    end
  end

  // calibration computation window after exit
  logic [15:0] calc_cnt_reg; // cycles of offset work left
  logic cal_seen_reg; // at least one sample gathered
  wire cal_busy = (calc_cnt_reg != 16'h0000);
  wire cal_done = (calc_cnt_reg == 16'h0001);
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      calc_cnt_reg <= 16'h0000;
      cal_seen_reg <= 1'b0;
    end else begin
      if (cal_off_cmd && cal_mode_reg) calc_cnt_reg <= `CMR_CALC_CYC;
      else if (cal_busy) calc_cnt_reg <= calc_cnt_reg - 16'h0001;
      if (cal_on_cmd) cal_seen_reg <= 1'b0;
      else if (cal_mode_reg && MAG_VALID) cal_seen_reg <= 1'b1;
    end
  end

  // per-axis extremes give hard-iron offset and span
  wire [15:0] mag_in [3];
  logic signed [15:0] min_reg [3];
  logic signed [15:0] max_reg [3];
  logic [15:0] ofs_reg [3];
  logic [15:0] span_reg [3];
  assign mag_in[0] = MAG_X;
  assign mag_in[1] = MAG_Y;
  assign mag_in[2] = MAG_Z;
  for (genvar g = 0; g < 3; g++) begin : g_axis
    wire signed [16:0] mid_sum = {max_reg[g][15], max_reg[g]} + {min_reg[g][15], min_reg[g]};
    wire [15:0] mid_val = mid_sum[16:1];
    wire [16:0] span_w = {max_reg[g][15], max_reg[g]} - {min_reg[g][15], min_reg[g]};
    // empty runs leave the old offsets in place
    always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
        min_reg[g] <= 16'h7FFF;
        max_reg[g] <= 16'h8000;
        ofs_reg[g] <= 16'h0000;
        span_reg[g] <= 16'h0000;
      end else begin
        if (cal_on_cmd) begin
          min_reg[g] <= 16'h7FFF;
          max_reg[g] <= 16'h8000;
        end else if (cal_mode_reg && MAG_VALID) begin
          if ($signed(mag_in[g]) < min_reg[g]) min_reg[g] <= mag_in[g];
          if ($signed(mag_in[g]) > max_reg[g]) max_reg[g] <= mag_in[g];
        end
        if (cal_done && cal_seen_reg) begin
          ofs_reg[g] <= mid_val;
          span_reg[g] <= span_w[15:0];
        end
      end
    end
  end
  assign CAL_OFFSET_X = ofs_reg[0];
  assign CAL_OFFSET_Y = ofs_reg[1];
  assign CAL_OFFSET_Z = ofs_reg[2];
  assign CAL_SPAN_X = span_reg[0];
  assign CAL_SPAN_Y = span_reg[1];
  assign CAL_SPAN_Z = span_reg[2];

  // status byte assembled from live state
  wire [7:0] status_byte = {comp_busy, cal_busy, filter_reg, run_reg,
                            stdby_reg, orient_reg};
  wire [7:0] ee_rd_byte = (wr_data == `CMR_OFS_STATUS) ? status_byte :
                          (wr_data == `CMR_OFS_RATE) ? rate_reg : 8'h00;

  // response buffer: heading, pitch, roll, each msb first
  logic [7:0] resp_mem [6];
  logic [2:0] resp_len_reg; // bytes the last command offers
  logic [2:0] rd_idx_reg; // next byte to hand out
  wire [47:0] rec_vec = {head_snap_reg, pitch_snap_reg, roll_snap_reg};
  for (genvar i = 0; i < 6; i++) begin : g_resp
    always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) resp_mem[i] <= 8'h00;
      else if (head_cmd) resp_mem[i] <= rec_vec[47-8*i -: 8];
      else if (ee_rd_load) resp_mem[i] <= (i == 0) ? ee_rd_byte : 8'h00;
    end
  end

  // read pointer; beyond the record the core returns zero
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      resp_len_reg <= 3'h0;
      rd_idx_reg <= 3'h0;
    end else begin
      if (head_cmd) resp_len_reg <= `CMR_RESP_LEN;
      else if (ee_rd_load) resp_len_reg <= 3'h1;
      else if (cmd_v) resp_len_reg <= 3'h0;
      if (rd_start) rd_idx_reg <= 3'h0;
      else if (rd_take && rd_idx_reg < resp_len_reg) rd_idx_reg <= rd_idx_reg + 3'h1;
    end
  end
  assign rd_byte = (rd_idx_reg < resp_len_reg) ? resp_mem[rd_idx_reg] : 8'h00;

  // checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESETN);
  sequence s_cal_close;
    cal_off_cmd && cal_mode_reg;
  endsequence
  sequence s_calc_run;
    status_byte[`CMR_BIT_CAL] [*8];
  endsequence
  sequence s_comp_run;
    status_byte[`CMR_BIT_COMP] [*8];
  endsequence
  a_early_bus_block: assert property (!ready_reg |-> !wr_valid && !wr_start)
    else $error("command taken before power-up wait ended");
  a_cal_entry: assert property (cal_on_cmd |=> cal_mode_reg)
    else $error("calibration entry command ignored");
  a_cal_exit_busy: assert property (s_cal_close |=> !cal_mode_reg ##0 s_calc_run)
    else $error("calibration exit did not raise busy bit");
  a_ofs_update: assert property (cal_done && cal_seen_reg |=>
                                 CAL_OFFSET_X == $past(g_axis[0].mid_val))
    else $error("offset not updated at calibration end");
  a_run_cmd_status: assert property (run_cmd |=> status_byte[`CMR_BIT_RUN]
                                     && !status_byte[`CMR_BIT_STDBY])
    else $error("run command did not reach status");
  a_stdby_cmd_status: assert property (stdby_cmd && !run_cmd |=> !run_reg ##0 stdby_reg)
    else $error("standby command did not reach status");
  a_orient_single: assert property ($onehot(status_byte[2:0]))
    else $error("orientation bits not one-hot");
  a_comp_flag: assert property (meas_tick |=> s_comp_run)
    else $error("compute bit not held after tick");
  a_head_order: assert property (head_cmd |=> resp_mem[0] == $past(head_snap_reg[15:8])
                                 && resp_mem[5] == $past(roll_snap_reg[7:0]))
    else $error("heading record out of order");
  a_angle_range: assert property (head_snap_reg <= `CMR_HEAD_MAX
                                  && $signed(pitch_snap_reg) >= TILT_MIN)
    else $error("angle outside documented span");
  a_rate_write: assert property (ee_wr_rate |=> rate_reg == $past(wr_data))
    else $error("rate byte write lost");
endmodule : cmr_top

// ===== pkg/cmr_params.svh
`ifndef CMR_PARAMS_SVH
`define CMR_PARAMS_SVH
// clock rate and timing figures
`define CMR_CLK_KHZ 100000
`define CMR_PWRUP_MS 5
`define CMR_PER_1HZ_MS 1000
`define CMR_PER_5HZ_MS 200
`define CMR_PER_10HZ_MS 100
`define CMR_COMP_CYC 8'h10
`define CMR_CALC_CYC 16'h0040
// bus address bytes (write form, read form)
`define CMR_ADDR_WR 8'h32
`define CMR_ADDR_RD 8'h33
// nonvolatile byte offsets and reset values
`define CMR_OFS_STATUS 8'h04
`define CMR_OFS_RATE 8'h05
`define CMR_RST_RATE 8'h01
`define CMR_RST_ORIENT 3'h1
// status byte bit positions
`define CMR_BIT_COMP 7
`define CMR_BIT_CAL 6
`define CMR_BIT_FILT 5
`define CMR_BIT_RUN 4
`define CMR_BIT_STDBY 3
// command bytes
`define CMR_CMD_HEAD 8'h50
`define CMR_CMD_CAL_ON 8'h70
`define CMR_CMD_LEVEL 8'h72
`define CMR_CMD_EDGE 8'h73
`define CMR_CMD_FRONT 8'h74
`define CMR_CMD_RUN 8'h75
`define CMR_CMD_STDBY 8'h76
`define CMR_CMD_CAL_OFF 8'h7F
`define CMR_CMD_EE_RD 8'hE1
`define CMR_CMD_EE_WR 8'hF1
// angle limits in tenths of a degree, record length
`define CMR_HEAD_MAX 16'h0E10
`define CMR_TILT_MAX 16'h0708
`define CMR_RESP_LEN 3'h6
`endif

// ===== pkg/cmr_pkg.sv
package cmr_pkg;
  // serial slave states
  typedef enum logic [2:0] {B_IDLE, B_ADDR, B_WR, B_SACK, B_RD, B_MACK} cmr_bus_st_t;
  // command byte parser states
  typedef enum logic [1:0] {P_CMD, P_EE_ADDR, P_EE_DATA, P_IGNORE} cmr_parse_st_t;
endpackage : cmr_pkg

// ===== core/cmr_rate_timer.sv
`timescale 1ns/1ns
`include "cmr_params.svh"
module cmr_rate_timer #(
  parameter int P1 = `CMR_PER_1HZ_MS * `CMR_CLK_KHZ,
  parameter int P5 = `CMR_PER_5HZ_MS * `CMR_CLK_KHZ,
  parameter int P10 = `CMR_PER_10HZ_MS * `CMR_CLK_KHZ
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [1:0] rate_sel,
  output logic tick
);
  localparam int CW = $clog2(P1 + 1);
  if (P10 < 2 || P5 < P10 || P1 < P5) begin : g_bad
    $error("rate periods must fall from 1Hz to 10Hz");
  end
  logic [CW-1:0] cnt_reg; // cycles since last tick
  // code 11 has no meaning, so it keeps the default 5Hz pace
  wire [CW-1:0] period = (rate_sel == 2'h0) ? CW'(P1) :
                         (rate_sel == 2'h2) ? CW'(P10) : CW'(P5);
  // >= rather than == so a switch to a faster rate never overruns
  wire wrap = (cnt_reg >= period - 1'b1);
  // free counter, held at zero outside continuous mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      tick <= 1'b0;
    end else begin
      tick <= run && wrap;
      cnt_reg <= (!run || wrap) ? '0 : cnt_reg + 1'b1;
    end
  end
endmodule : cmr_rate_timer

// ===== core/cmr_i2c_slave.sv
`timescale 1ns/1ns
`include "cmr_params.svh"
module cmr_i2c_slave
  import cmr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic accept,
  input wire logic [7:0] rd_data,
  output logic wr_start,
  output logic wr_valid,
  output logic [7:0] wr_data,
  output logic rd_start,
  output logic rd_take
);
  localparam logic [7:0] ADDR = `CMR_ADDR_WR;
  logic [2:0] scl_sync_reg; // bit 0 is the metastable stage
  logic [2:0] sda_sync_reg;
  logic scl_reg, sda_reg, scl_old_reg, sda_old_reg;
  cmr_bus_st_t st_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg, tx_reg;
  logic rd_mode_reg, mack_reg;
  // three stages; a level counts once stages two and three agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      {scl_reg, sda_reg, scl_old_reg, sda_old_reg} <= 4'hF;
    end else begin
      scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
      sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
      if (scl_sync_reg[1] == scl_sync_reg[2]) scl_reg <= scl_sync_reg[2];
      if (sda_sync_reg[1] == sda_sync_reg[2]) sda_reg <= sda_sync_reg[2];
      scl_old_reg <= scl_reg;
      sda_old_reg <= sda_reg;
    end
  end
  wire scl_rise = scl_reg & ~scl_old_reg;
  wire scl_fall = ~scl_reg & scl_old_reg;
  wire bus_start = scl_reg & scl_old_reg & sda_old_reg & ~sda_reg;
  wire bus_stop = scl_reg & scl_old_reg & ~sda_old_reg & sda_reg;
  wire byte_in = (bit_cnt_reg == 4'h8);
  // address is refused (no ack) while the core is not ready
  wire addr_hit = (shift_reg[7:1] == ADDR[7:1]) && accept;
  wire addr_end = scl_fall && (st_reg == B_ADDR) && byte_in && addr_hit;
  wire load_next = scl_fall && ((st_reg == B_SACK && rd_mode_reg) ||
                                (st_reg == B_MACK && mack_reg));
  assign wr_start = addr_end && !shift_reg[0];
  assign rd_start = addr_end && shift_reg[0]; // lsb set selects read
  assign wr_valid = scl_fall && (st_reg == B_WR) && byte_in;
  assign wr_data = shift_reg;
  assign rd_take = load_next;
  assign sda_out = 1'b0; // open drain: only ever pulls low
  // bit engine: sample on rising scl, change sda on falling scl
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= B_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      sda_oe <= 1'b0;
      rd_mode_reg <= 1'b0;
      mack_reg <= 1'b0;
    end else if (bus_start) begin
      st_reg <= B_ADDR;
      bit_cnt_reg <= 4'h0;
      sda_oe <= 1'b0;
    end else if (bus_stop) begin
      st_reg <= B_IDLE;
      sda_oe <= 1'b0;
    end else if (scl_rise) begin
      if (st_reg == B_ADDR || st_reg == B_WR) begin
        shift_reg <= {shift_reg[6:0], sda_reg};
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end
      if (st_reg == B_MACK) mack_reg <= ~sda_reg; // master ack is low
    end else if (load_next) begin
      tx_reg <= {rd_data[6:0], 1'b0};
      sda_oe <= ~rd_data[7]; // msb first
      bit_cnt_reg <= 4'h1;
      st_reg <= B_RD;
    end else if (scl_fall) begin
      case (st_reg)
        B_ADDR: begin
          if (byte_in) begin
            sda_oe <= addr_hit;
            rd_mode_reg <= shift_reg[0];
            st_reg <= addr_hit ? B_SACK : B_IDLE;
          end
        end
        B_WR: begin
          if (byte_in) begin
            sda_oe <= 1'b1;
            st_reg <= B_SACK;
          end
        end
        B_SACK: begin
          sda_oe <= 1'b0;
          bit_cnt_reg <= 4'h0;
          st_reg <= B_WR;
        end
        B_RD: begin
          if (byte_in) begin
            sda_oe <= 1'b0;
            st_reg <= B_MACK;
          end else begin
            sda_oe <= ~tx_reg[7];
            tx_reg <= {tx_reg[6:0], 1'b0};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
        end
        B_MACK: st_reg <= B_IDLE; // nack ends the read
        default: st_reg <= B_IDLE;
      endcase
    end
  end
endmodule : cmr_i2c_slave

// ===== verif/cmr_host_model.sv
`timescale 1ns/1ns
`include "cmr_params.svh"
// host controller as bus master; it drives scl both high and low and only ever pulls the open-drain sda line low
module cmr_host_model (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_pull
);
  // both lines released at time zero, bus idle
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // whole cycles; every change lands on a falling edge
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  // data moves well after the low edge, so the core never sees a false start
  task automatic xfer(input logic b, output logic r);
    cyc(6);
    sda_pull = ~b;
    cyc(4);
    scl = 1'b1;
    cyc(1);
    r = sda;
    cyc(9);
    scl = 1'b0;
  endtask : xfer
  // eight bits msb first, then the acknowledge slot
  task automatic xbyte(input logic [7:0] d, input logic ak, output logic [7:0] q,
      output logic got);
    for (int i = 7; i >= 0; i--) xfer(d[i], q[i]);
    xfer(ak, got);
    got = ~got;
  endtask : xbyte
  // start: data falls while the clock is high
  task automatic start;
    cyc(10);
    sda_pull = 1'b1;
    cyc(10);
    scl = 1'b0;
  endtask : start
  // stop: data rises while the clock is high
  task automatic stop;
    cyc(6);
    sda_pull = 1'b1;
    cyc(4);
    scl = 1'b1;
    cyc(10);
    sda_pull = 1'b0;
    cyc(10);
  endtask : stop
  // write frame, ok tells whether the address was acknowledged
  task automatic send(input logic [23:0] c, input int n, output logic ok);
    logic [7:0] q;
    logic a;
    start;
    xbyte(`CMR_ADDR_WR, 1'b1, q, ok);
    for (int k = 0; k < n; k++) xbyte(c[23-8*k -: 8], 1'b1, q, a);
    stop;
  endtask : send
  // read frame: master acks every byte but the last
  task automatic fetch(input int n, output logic [47:0] q, output logic ok);
    logic [7:0] b;
    logic a;
    start;
    xbyte(`CMR_ADDR_RD, 1'b1, b, ok);
    for (int k = 0; k < n; k++) begin
      xbyte(8'hFF, k == n - 1, b, a);
      q = {q[39:0], b};
    end
    stop;
  endtask : fetch
endmodule : cmr_host_model

// ===== verif/compass_mode_and_readout_tb_top.sv
`timescale 1ns/1ns
`include "cmr_params.svh"
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin errors++; \
  $display("FAIL %0t got %h exp %h", $time, (a), (e)); end end
module compass_mode_and_readout_tb_top;
  localparam int PWR = 400; // shortened power-up refusal window
  localparam logic [47:0] RAW [2] = '{48'h0123_FFFB_0708, 48'h0F00_0800_F830};
  localparam logic [47:0] EXP [2] = '{48'h0123_FFFB_0708, 48'h0E10_0708_F8F8};
  localparam logic [7:0] CMDS [5] = '{`CMR_CMD_EDGE, `CMR_CMD_FRONT, `CMR_CMD_LEVEL,
    `CMR_CMD_STDBY, `CMR_CMD_RUN};
  localparam logic [7:0] STS [5] = '{8'h12, 8'h14, 8'h11, 8'h09, 8'h11};
  logic CLOCK, RESETN, scl, sda_pull, sda, sda_oe, sda_o, ok, mag_v;
  logic [15:0] head, pitch, roll, mx, my, mz, ox, oy, oz, sx, sy, sz;
  logic [47:0] q;
  int errors, total_checks;
  // open-drain data line with pull-up: low if either side pulls
  assign sda = ~(sda_pull | sda_oe);
  cmr_top #(.PWRUP_CYC(PWR), .PER_1HZ(4000), .PER_5HZ(2000), .PER_10HZ(1000)) DUT (
    .CLOCK(CLOCK), .RESETN(RESETN), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_o),
    .SDA_OE(sda_oe), .HEADING_RAW(head), .PITCH_RAW(pitch), .ROLL_RAW(roll),
    .MAG_X(mx), .MAG_Y(my), .MAG_Z(mz), .MAG_VALID(mag_v), .CAL_OFFSET_X(ox),
    .CAL_OFFSET_Y(oy), .CAL_OFFSET_Z(oz), .CAL_SPAN_X(sx), .CAL_SPAN_Y(sy),
    .CAL_SPAN_Z(sz));
  cmr_host_model HOST (.clk(CLOCK), .sda(sda), .scl(scl), .sda_pull(sda_pull));
  // 100 MHz clock
  initial begin
    CLOCK = 1'b0;
    forever #5 CLOCK = ~CLOCK;
  end
  // hang guard, well beyond the expected run length
  initial begin
    repeat (100000) @(posedge CLOCK);
    errors++;
    wrap_up();
  end
  // counts, verdict, end of run
  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up
  // one command frame, then time for the core to act on it
  task automatic cmd(input logic [23:0] c, input int n);
    HOST.send(c, n, ok);
    `CHK(ok, 1'b1)
    HOST.cyc(100);
  endtask : cmd
  // nonvolatile byte through the read-byte command and a one-byte read
  task automatic nv_rd(input logic [7:0] ofs, input logic [7:0] e);
    cmd({`CMR_CMD_EE_RD, ofs, 8'h00}, 2);
    HOST.fetch(1, q, ok);
    `CHK(q[7:0], e)
  endtask : nv_rd
  // one magnetometer sample, valid for a single cycle
  task automatic mag(input logic [47:0] v);
    {mx, my, mz} = v;
    mag_v = 1'b1;
    @(negedge CLOCK);
    mag_v = 1'b0;
  endtask : mag
  // main sequence
  initial begin
    errors = 0;
    total_checks = 0;
    RESETN = 1'b0;
    {head, pitch, roll} = RAW[0];
    {mx, my, mz} = 48'h0;
    mag_v = 1'b0;
    repeat (16) @(posedge CLOCK);
    @(negedge CLOCK) RESETN = 1'b1;
    // too early: the address must go unacknowledged
    HOST.send(24'h0, 0, ok);
    `CHK(ok, 1'b0)
    HOST.cyc(PWR);
    nv_rd(`CMR_OFS_STATUS, 8'h11);
    nv_rd(`CMR_OFS_RATE, `CMR_RST_RATE);
    // plain and clamped angles; wait past one 5Hz update before asking
    for (int i = 0; i < 2; i++) begin
      {head, pitch, roll} = RAW[i];
      HOST.cyc(2500);
      cmd({`CMR_CMD_HEAD, 16'h0}, 1);
      HOST.fetch(6, q, ok);
      `CHK(q, EXP[i])
    end
    // orientation and mode commands; none of them offers response bytes
    for (int i = 0; i < 5; i++) begin
      cmd({CMDS[i], 16'h0}, 1);
      HOST.fetch(1, q, ok);
      `CHK(q[7:0], 8'h00)
      nv_rd(`CMR_OFS_STATUS, STS[i]);
    end
    // rate change with upper bits clear, then all ones at status
    cmd({`CMR_CMD_EE_WR, `CMR_OFS_RATE, 8'h02}, 3);
    nv_rd(`CMR_OFS_RATE, 8'h02);
    cmd({`CMR_CMD_EE_WR, `CMR_OFS_STATUS, 8'hFF}, 3);
    nv_rd(`CMR_OFS_STATUS, 8'h31);
    // a sample outside calibration must be ignored
    mag(48'h7000_7000_7000);
    cmd({`CMR_CMD_CAL_ON, 16'h0}, 1);
    mag(48'h0064_0032_FFEC);
    mag(48'hFF9C_000A_FFC4);
    cmd({`CMR_CMD_CAL_OFF, 16'h0}, 1);
    `CHK({ox, oy, oz, sx, sy, sz}, 96'h0000_001E_FFD8_00C8_0028_0028)
    // the data line is open drain, so its driven value must stay low
    `CHK(sda_o, 1'b0)
    wrap_up();
  end
endmodule : compass_mode_and_readout_tb_top
